//--- rtl/bsf_exec_unit.sv
// execution unit for bit, shift and flag operations of an 8-bit core
// assumes the core presents the operand register value with the command and
// returns I/O read data combinationally in the cycle io_rd_out is high
//
// Overview of operation
// - io_bit_setter forces I/O bit b to one, flags kept, two cycles.
// - io_bit_clearer forces I/O bit b to zero, flags kept, two cycles.
// - shift_toward_msb moves bits up, zero into bit 0, sets Z C N V.
// - shift_toward_lsb moves bits down, zero into bit 7, sets Z C N V.
// - rotate_up_via_carry: carry into bit 0, bit 7 into carry, Z N V.
// - rotate_down_via_carry: carry into bit 7, bit 0 into carry, Z N V.
// - signed_halving_shift keeps bit 7, shifts down, sets Z C N V.
// - nibble exchange swaps high and low halves in one cycle.
// - status_flag_raise/drop writes one/zero to flag b only.
// - copy_bit_to_spare_flag writes source bit b into spare flag only.
// - copy_spare_flag_to_bit writes spare flag into destination bit b.
// - carry_raise and carry_drop set or clear carry only, one cycle.
// - negative_raise and negative_drop set or clear negative only.
// - zero_raise and zero_drop set or clear zero only, one cycle.
`timescale 1ns/10ps
module bsf_exec_unit
  import bsf_pkg::*;
(
  input  wire logic                  clk_in,
  input  wire logic                  rst_n_in,
  // command
  input  wire logic                  cmd_valid_in,
  input  wire bsf_op_t               cmd_op_in,
  input  wire logic [REG_ADDR_W-1:0] cmd_reg_addr_in,
  input  wire logic [DATA_W-1:0]     cmd_reg_data_in,
  input  wire logic [BIT_SEL_W-1:0]  cmd_bit_sel_in,
  input  wire logic [IO_ADDR_W-1:0]  cmd_io_addr_in,
  output logic                       cmd_ready_out,
  output logic                       done_out,
  // working register write port
  output logic                       reg_we_out,
  output logic [REG_ADDR_W-1:0]      reg_waddr_out,
  output logic [DATA_W-1:0]          reg_wdata_out,
  // I/O space port
  output logic                       io_rd_out,
  output logic                       io_we_out,
  output logic [IO_ADDR_W-1:0]       io_addr_out,
  output logic [DATA_W-1:0]          io_wdata_out,
  input  wire logic [DATA_W-1:0]     io_rdata_in,
  // status flags register
  output logic [DATA_W-1:0]          status_flags_out
);

  bsf_state_t              state_q,   state_d;
  logic [DATA_W-1:0]       status_flags_register_q,    status_flags_register_d;
  logic                    reg_we_q,  reg_we_d;
  logic [REG_ADDR_W-1:0]   waddr_q,   waddr_d;
  logic [DATA_W-1:0]       wdata_q,   wdata_d;
  logic                    io_rd_q,   io_rd_d;
  logic                    io_we_q,   io_we_d;
  logic [IO_ADDR_W-1:0]    io_addr_q, io_addr_d;
  logic [DATA_W-1:0]       io_wdat_q, io_wdat_d;
  logic [BIT_SEL_W-1:0]    bit_q,     bit_d;
  logic                    io_set_q,  io_set_d;
  logic                    done_q,    done_d;

  logic [DATA_W-1:0]       sh_result;
  logic                    sh_carry;
  logic                    sh_zero;
  logic                    sh_neg;
  logic                    sh_ovf;
  logic                    sh_flags;
  logic                    accept;

  // shift datapath sees the operand and the carry held before this op
  bsf_shift_unit u_shift (
    .op_in           (cmd_op_in),
    .data_in         (cmd_reg_data_in),
    .carry_in        (status_flags_register_q[FLAG_C_POS]),
    .result_out      (sh_result),
    .carry_out       (sh_carry),
    .zero_out        (sh_zero),
    .negative_out    (sh_neg),
    .overflow_out    (sh_ovf),
    .flags_valid_out (sh_flags)
  );

  // no new command while the I/O read cycle is in progress
  assign cmd_ready_out = (state_q == ST_IDLE);
  assign accept        = cmd_valid_in && cmd_ready_out;

  // one command per idle cycle; io ops hold the unit for a second cycle
  always_comb begin
    state_d   = state_q;
    status_flags_register_d    = status_flags_register_q;          // untouched flags hold
    reg_we_d  = 1'b0;
    waddr_d   = waddr_q;
    wdata_d   = wdata_q;
    io_rd_d   = 1'b0;
    io_we_d   = 1'b0;
    io_addr_d = io_addr_q;
    io_wdat_d = io_wdat_q;
    bit_d     = bit_q;
    io_set_d  = io_set_q;
    done_d    = 1'b0;
    unique case (state_q)
      ST_IDLE: begin
        if (accept) begin
          done_d = 1'b1;
          unique case (cmd_op_in)
            OP_IO_BIT_SETTER, OP_IO_BIT_CLEARER: begin
              // read phase first, write follows; flags untouched
              done_d    = 1'b0;
              state_d   = ST_IO_READ;
              io_rd_d   = 1'b1;
              io_addr_d = cmd_io_addr_in;
              bit_d     = cmd_bit_sel_in;
              io_set_d  = (cmd_op_in == OP_IO_BIT_SETTER);
            end
            OP_SHIFT_TOWARD_MSB, OP_SHIFT_TOWARD_LSB, OP_ROTATE_UP_VIA_CARRY,
            OP_ROTATE_DOWN_VIA_CARRY, OP_SIGNED_HALVING_SHIFT,
            OP_NIBBLE_EXCHANGE: begin
              reg_we_d = 1'b1;
              waddr_d  = cmd_reg_addr_in;
              wdata_d  = sh_result;
              // nibble exchange leaves every flag as it was
              if (sh_flags) begin
                status_flags_register_d[FLAG_C_POS] = sh_carry;
                status_flags_register_d[FLAG_Z_POS] = sh_zero;
                status_flags_register_d[FLAG_N_POS] = sh_neg;
                status_flags_register_d[FLAG_V_POS] = sh_ovf;
              end
            end
            OP_STATUS_FLAG_RAISE: begin
              status_flags_register_d[cmd_bit_sel_in] = 1'b1;
            end
            OP_STATUS_FLAG_DROP: begin
              status_flags_register_d[cmd_bit_sel_in] = 1'b0;
            end
            OP_COPY_BIT_TO_SPARE_FLAG: begin
              status_flags_register_d[FLAG_SPARE_POS] = cmd_reg_data_in[cmd_bit_sel_in];
            end
            OP_COPY_SPARE_FLAG_TO_BIT: begin
              reg_we_d                = 1'b1;
              waddr_d                 = cmd_reg_addr_in;
              wdata_d                 = cmd_reg_data_in;
              wdata_d[cmd_bit_sel_in] = status_flags_register_q[FLAG_SPARE_POS];
            end
            OP_CARRY_RAISE: begin
              status_flags_register_d[FLAG_C_POS] = 1'b1;
            end
            OP_CARRY_DROP: begin
              status_flags_register_d[FLAG_C_POS] = 1'b0;
            end
            OP_NEGATIVE_RAISE: begin
              status_flags_register_d[FLAG_N_POS] = 1'b1;
            end
            OP_NEGATIVE_DROP: begin
              status_flags_register_d[FLAG_N_POS] = 1'b0;
            end
            OP_ZERO_RAISE: begin
              status_flags_register_d[FLAG_Z_POS] = 1'b1;
            end
            OP_ZERO_DROP: begin
              status_flags_register_d[FLAG_Z_POS] = 1'b0;
            end
            default: begin
              // unused op codes are accepted and do nothing
              done_d = 1'b1;
            end
          endcase
        end
      end
      ST_IO_READ: begin
        // second cycle: modify the returned byte and write it back
        // read data is taken at the edge that ends the read cycle
        state_d            = ST_IDLE;
        io_we_d            = 1'b1;
        done_d             = 1'b1;
        io_wdat_d          = io_rdata_in;
        io_wdat_d[bit_q]   = io_set_q;
      end
    endcase
  end

  // register stage: every data output comes straight from these flops
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      state_q   <= ST_IDLE;
      status_flags_register_q    <= STATUS_FLAGS_RESET;
      reg_we_q  <= 1'b0;
      waddr_q   <= '0;
      wdata_q   <= '0;
      io_rd_q   <= 1'b0;
      io_we_q   <= 1'b0;
      io_addr_q <= '0;
      io_wdat_q <= '0;
      bit_q     <= '0;
      io_set_q  <= 1'b0;
      done_q    <= 1'b0;
    end else begin
      state_q   <= state_d;
      status_flags_register_q    <= status_flags_register_d;
      reg_we_q  <= reg_we_d;
      waddr_q   <= waddr_d;
      wdata_q   <= wdata_d;
      io_rd_q   <= io_rd_d;
      io_we_q   <= io_we_d;
      io_addr_q <= io_addr_d;
      io_wdat_q <= io_wdat_d;
      bit_q     <= bit_d;
      io_set_q  <= io_set_d;
      done_q    <= done_d;
    end
  end

  // outputs driven only from registered state
  assign done_out         = done_q;
  assign reg_we_out       = reg_we_q;
  assign reg_waddr_out    = waddr_q;
  assign reg_wdata_out    = wdata_q;
  assign io_rd_out        = io_rd_q;
  assign io_we_out        = io_we_q;
  assign io_addr_out      = io_addr_q;
  assign io_wdata_out     = io_wdat_q;
  assign status_flags_out = status_flags_register_q;

endmodule // bsf_exec_unit

//--- rtl/bsf_pkg.sv
// constants and types shared by the bit, shift and flag execution unit
// assumes an 8-bit core with an 8-bit status flags register
package bsf_pkg;

  localparam int DATA_W    = 8;
  localparam int BIT_SEL_W = 3;
  localparam int IO_ADDR_W = 6;
  localparam int REG_ADDR_W = 5;

  // status flags register bit positions
  localparam int FLAG_C_POS     = 0;
  localparam int FLAG_Z_POS     = 1;
  localparam int FLAG_N_POS     = 2;
  localparam int FLAG_V_POS     = 3;
  localparam int FLAG_S_POS     = 4;
  localparam int FLAG_H_POS     = 5;
  localparam int FLAG_SPARE_POS = 6;
  localparam int FLAG_I_POS     = 7;

  localparam logic [7:0] STATUS_FLAGS_RESET = 8'h00;

  // cycles per operation class
  localparam int IO_OP_CYCLES  = 2;
  localparam int REG_OP_CYCLES = 1;

  typedef enum logic [4:0] {
    OP_IO_BIT_SETTER,
    OP_IO_BIT_CLEARER,
    OP_SHIFT_TOWARD_MSB,
    OP_SHIFT_TOWARD_LSB,
    OP_ROTATE_UP_VIA_CARRY,
    OP_ROTATE_DOWN_VIA_CARRY,
    OP_SIGNED_HALVING_SHIFT,
    OP_NIBBLE_EXCHANGE,
    OP_STATUS_FLAG_RAISE,
    OP_STATUS_FLAG_DROP,
    OP_COPY_BIT_TO_SPARE_FLAG,
    OP_COPY_SPARE_FLAG_TO_BIT,
    OP_CARRY_RAISE,
    OP_CARRY_DROP,
    OP_NEGATIVE_RAISE,
    OP_NEGATIVE_DROP,
    OP_ZERO_RAISE,
    OP_ZERO_DROP
  } bsf_op_t;

  typedef enum logic {
    ST_IDLE,
    ST_IO_READ
  } bsf_state_t;

endpackage

//--- rtl/bsf_shift_unit.sv
// combinational shift, rotate and nibble exchange datapath with flag results
// assumes the caller registers results and decides when flags are written
`timescale 1ns/10ps
module bsf_shift_unit
  import bsf_pkg::*;
(
  input  wire bsf_op_t          op_in,
  input  wire logic [DATA_W-1:0] data_in,
  input  wire logic             carry_in,
  output logic      [DATA_W-1:0] result_out,
  output logic                  carry_out,
  output logic                  zero_out,
  output logic                  negative_out,
  output logic                  overflow_out,
  output logic                  flags_valid_out
);

  always_comb begin
    result_out      = data_in;
    carry_out       = carry_in;
    flags_valid_out = 1'b1;
    unique case (op_in)
      OP_SHIFT_TOWARD_MSB: begin
        result_out = {data_in[DATA_W-2:0], 1'b0};
        carry_out  = data_in[DATA_W-1];
      end
      OP_SHIFT_TOWARD_LSB: begin
        result_out = {1'b0, data_in[DATA_W-1:1]};
        carry_out  = data_in[0];
      end
      OP_ROTATE_UP_VIA_CARRY: begin
        result_out = {data_in[DATA_W-2:0], carry_in};
        carry_out  = data_in[DATA_W-1];
      end
      OP_ROTATE_DOWN_VIA_CARRY: begin
        result_out = {carry_in, data_in[DATA_W-1:1]};
        carry_out  = data_in[0];
      end
      OP_SIGNED_HALVING_SHIFT: begin
        result_out = {data_in[DATA_W-1], data_in[DATA_W-1:1]};
        carry_out  = data_in[0];
      end
      OP_NIBBLE_EXCHANGE: begin
        result_out      = {data_in[3:0], data_in[7:4]};
        flags_valid_out = 1'b0;
      end
      default: begin
        flags_valid_out = 1'b0;
      end
    endcase
  end

  assign zero_out     = (result_out == '0);
  assign negative_out = result_out[DATA_W-1];
  // overflow follows negative xor carry after the shift
  assign overflow_out = negative_out ^ carry_out;

endmodule // bsf_shift_unit

//--- testbench/bsf_exec_sva.sv
// assertions for the bit, shift and flag unit
// bound to bsf_exec_unit, sees only its ports
`timescale 1ns/10ps
module bsf_exec_sva
  import bsf_pkg::*;
(
  input wire logic       clk_in,
  input wire logic       rst_n_in,
  input wire logic       cmd_valid_in,
  input wire bsf_op_t    cmd_op_in,
  input wire logic [7:0] cmd_reg_data_in,
  input wire logic [2:0] cmd_bit_sel_in,
  input wire logic       cmd_ready_out,
  input wire logic       done_out,
  input wire logic       reg_we_out,
  input wire logic [7:0] reg_wdata_out,
  input wire logic       io_rd_out,
  input wire logic       io_we_out,
  input wire logic [7:0] status_flags_out
);
  logic [7:0] d_q;
  logic [7:0] f_q;
  logic [2:0] b_q;
  logic       tk;
  assign tk = cmd_valid_in && cmd_ready_out;
  // operands and flags as seen at the taking edge
  always_ff @(posedge clk_in) begin
    d_q <= cmd_reg_data_in;
    f_q <= status_flags_out;
    b_q <= cmd_bit_sel_in;
  end
  default clocking @(posedge clk_in); endclocking
  default disable iff (!rst_n_in);
  sequence s_io_rd;
    io_rd_out && !cmd_ready_out && !done_out;
  endsequence
  sequence s_io_we;
    io_we_out && done_out && cmd_ready_out;
  endsequence
  a_io_steps: assert property (
    tk && cmd_op_in == OP_IO_BIT_SETTER |=> s_io_rd ##1 s_io_we)
    else $error("io set steps wrong");
  a_io_flags_kept: assert property (
    tk && cmd_op_in == OP_IO_BIT_CLEARER |=> ($stable(status_flags_out))[*2])
    else $error("io clear touched flags");
  a_msb_shift: assert property (
    tk && cmd_op_in == OP_SHIFT_TOWARD_MSB |=> reg_we_out && done_out
    && reg_wdata_out == {d_q[6:0], 1'b0} && status_flags_out[0] == d_q[7])
    else $error("msb shift wrong");
  a_rotate_down: assert property (
    tk && cmd_op_in == OP_ROTATE_DOWN_VIA_CARRY |=>
    reg_wdata_out == {f_q[0], d_q[7:1]} && status_flags_out[0] == d_q[0])
    else $error("rotate down wrong");
  a_nibble_swap: assert property (
    tk && cmd_op_in == OP_NIBBLE_EXCHANGE |=>
    reg_wdata_out == {d_q[3:0], d_q[7:4]} && $stable(status_flags_out))
    else $error("nibble exchange wrong");
  a_flag_raise: assert property (
    tk && cmd_op_in == OP_STATUS_FLAG_RAISE |=>
    status_flags_out == (f_q | (8'h01 << b_q)) && !reg_we_out)
    else $error("flag raise wrong");
  a_spare_copy: assert property (
    tk && cmd_op_in == OP_COPY_BIT_TO_SPARE_FLAG |=>
    status_flags_out == {f_q[7], d_q[b_q], f_q[5:0]})
    else $error("spare flag copy wrong");
  a_carry_drop: assert property (
    tk && cmd_op_in == OP_CARRY_DROP |=> status_flags_out == (f_q & 8'hfe))
    else $error("carry drop wrong");
endmodule // bsf_exec_sva
bind bsf_exec_unit bsf_exec_sva u_sva (.*);

//--- testbench/testbench.sv
// self-checking bench for bsf_exec_unit
// drives commands itself, no outside model
`timescale 1ns/10ps
module testbench;
  import bsf_pkg::*;
  logic        clk_in, rst_n_in, cmd_valid_in, cmd_ready_out, done_out;
  logic        reg_we_out, io_rd_out, io_we_out;
  bsf_op_t     cmd_op_in;
  logic [4:0]  cmd_reg_addr_in, reg_waddr_out;
  logic [7:0]  cmd_reg_data_in, io_rdata_in, reg_wdata_out, io_wdata_out;
  logic [7:0]  status_flags_out, fl;
  logic [2:0]  cmd_bit_sel_in;
  logic [5:0]  cmd_io_addr_in, io_addr_out;
  logic [23:0] exp_q[$];
  int          seed = 92, errors = 0, cmp_count = 0, cyc = 0;
  bsf_exec_unit DUT (.*);
  initial begin
    clk_in = 1'b0;
    forever #12.5 clk_in = ~clk_in;
  end
  task automatic chk(string n, logic [23:0] e, logic [23:0] s);
    cmp_count++;
    if (e !== s) begin
      errors++;
      $display("mismatch %s exp %h got %h", n, e, s);
    end
  endtask
  task automatic final_report();
    $display("compares %0d mismatches %0d", cmp_count, errors);
    if (errors == 0 && cmp_count > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  task automatic run(bsf_op_t op, logic [7:0] d, logic [2:0] b);
    logic [7:0] r;
    logic       w;
    logic       io;
    logic [4:0] ra;
    logic [5:0] ia;
    r = d;
    io = op inside {OP_IO_BIT_SETTER, OP_IO_BIT_CLEARER};
    w = op inside {[OP_SHIFT_TOWARD_MSB:OP_NIBBLE_EXCHANGE], OP_COPY_SPARE_FLAG_TO_BIT};
    case (op)
      OP_IO_BIT_SETTER:          r = d | (8'h01 << b);
      OP_IO_BIT_CLEARER:         r = d & ~(8'h01 << b);
      OP_SHIFT_TOWARD_MSB:       {fl[0], r} = {d, 1'b0};
      OP_SHIFT_TOWARD_LSB:       {r, fl[0]} = {1'b0, d};
      OP_ROTATE_UP_VIA_CARRY:    {fl[0], r} = {d, fl[0]};
      OP_ROTATE_DOWN_VIA_CARRY:  {r, fl[0]} = {fl[0], d};
      OP_SIGNED_HALVING_SHIFT:   {r, fl[0]} = {d[7], d};
      OP_NIBBLE_EXCHANGE:        r = {d[3:0], d[7:4]};
      OP_STATUS_FLAG_RAISE:      fl[b] = 1'b1;
      OP_STATUS_FLAG_DROP:       fl[b] = 1'b0;
      OP_COPY_BIT_TO_SPARE_FLAG: fl[6] = d[b];
      OP_COPY_SPARE_FLAG_TO_BIT: r[b] = fl[6];
      OP_CARRY_RAISE:            fl[0] = 1'b1;
      OP_CARRY_DROP:             fl[0] = 1'b0;
      OP_NEGATIVE_RAISE:         fl[2] = 1'b1;
      OP_NEGATIVE_DROP:          fl[2] = 1'b0;
      OP_ZERO_RAISE:             fl[1] = 1'b1;
      default:                   fl[1] = 1'b0;
    endcase
    if (op inside {[OP_SHIFT_TOWARD_MSB:OP_SIGNED_HALVING_SHIFT]}) begin
      fl[1] = (r == 8'h00);
      fl[2] = r[7];
      fl[3] = r[7] ^ fl[0];
    end
    if (!w && !io)
      r = 8'h00;
    ra = 5'($random(seed));
    ia = 6'($random(seed));
    exp_q.push_back({w, io, w ? {1'b0, ra} : io ? ia : 6'h00, r, fl});
    cmd_valid_in <= 1'b1;
    cmd_op_in <= op;
    cmd_reg_data_in <= d;
    cmd_bit_sel_in <= b;
    io_rdata_in <= d;
    cmd_reg_addr_in <= ra;
    cmd_io_addr_in <= ia;
    @(posedge clk_in);
    if (io) begin
      // offered while busy, must be ignored
      cmd_op_in <= OP_CARRY_RAISE;
      @(posedge clk_in);
    end
  endtask
  always @(negedge clk_in) begin
    if (rst_n_in && done_out === 1'b1) begin
      if (exp_q.size() == 0)
        chk("done", 24'h0, 24'hffffff);
      else
        chk("result", exp_q.pop_front(), {reg_we_out, io_we_out,
            reg_we_out ? {1'b0, reg_waddr_out} : io_we_out ? io_addr_out : 6'h00,
            reg_we_out ? reg_wdata_out : io_we_out ? io_wdata_out : 8'h00, status_flags_out});
    end
  end
  always @(posedge clk_in) begin
    cyc++;
    if (cyc == 3000) begin
      errors++;
      final_report();
    end
  end
  initial begin
    rst_n_in = 1'b0;
    cmd_valid_in = 1'b0;
    cmd_op_in = OP_CARRY_DROP;
    cmd_reg_addr_in = 5'h00;
    cmd_reg_data_in = 8'h00;
    cmd_bit_sel_in = 3'h0;
    cmd_io_addr_in = 6'h00;
    io_rdata_in = 8'h00;
    fl = STATUS_FLAGS_RESET;
    repeat (2) @(posedge clk_in);
    rst_n_in <= 1'b1;
    @(negedge clk_in);
    chk("reset", {16'h0001, STATUS_FLAGS_RESET}, {15'h0, cmd_ready_out, status_flags_out});
    $display("test reset done");
    @(posedge clk_in);
    run(OP_SHIFT_TOWARD_MSB, 8'h80, 3'h0);
    run(OP_ROTATE_DOWN_VIA_CARRY, 8'h01, 3'h0);
    run(OP_SIGNED_HALVING_SHIFT, 8'h81, 3'h0);
    run(OP_ROTATE_UP_VIA_CARRY, 8'h7f, 3'h7);
    for (int i = 0; i < 18; i++)
      run(bsf_op_t'(i), 8'($random(seed)), 3'($random(seed)));
    $display("test directed done");
    for (int i = 0; i < 300; i++)
      run(bsf_op_t'($unsigned($random(seed)) % 18), 8'($random(seed)), 3'($random(seed)));
    cmd_valid_in <= 1'b0;
    repeat (3) @(posedge clk_in);
    rst_n_in <= 1'b0;
    @(posedge clk_in);
    rst_n_in <= 1'b1;
    fl = STATUS_FLAGS_RESET;
    run(OP_NEGATIVE_RAISE, 8'h00, 3'h0);
    cmd_valid_in <= 1'b0;
    repeat (3) @(posedge clk_in);
    chk("left", 24'h0, 24'(exp_q.size()));
    $display("test random and reset done");
    final_report();
  end
endmodule // testbench
